// file: hw/fesp_regs.svh
// Register map, field positions and timing counts of the flash sequencer.
// Assumes a 100 MHz core clock and a byte-wide parallel NOR flash.
// How it works
// - After a time-out the reset command must precede any new program/erase.
// - Read erase_window_flag before and after each extra sector erase.
// - Write only with chip select and write strobe low, output enable high.
// - Protect: high voltage on pin nine and output enable, one strobe pulse.
// - Unprotect: high voltage, chip select low, address bit six high, pulse.
// - Protect every sector before running chip unprotect.
`ifndef FESP_REGS_SVH
`define FESP_REGS_SVH
`define FESP_CTRL_OFS 8'h00
`define FESP_ADDR_OFS 8'h04
`define FESP_WDATA_OFS 8'h08
`define FESP_STATUS_OFS 8'h0C
`define FESP_RDATA_OFS 8'h10
`define FESP_HV_OFS 8'h14
`define FESP_CTRL_GO 0
`define FESP_CTRL_OP_LSB 1
`define FESP_CTRL_CHK 4
`define FESP_HV_RST 0
`define FESP_HV_A9 1
`define FESP_RESP_OK 2'h0
`define FESP_RESP_ERR 2'h2
`define FESP_BIT_POLL 7
`define FESP_BIT_TOGGLE 6
`define FESP_BIT_TIMEOUT 5
`define FESP_BIT_WINDOW 3
`define FESP_UNPROT_ABIT 6
`define FESP_CMD_RESET 8'hF0
`define FESP_CLK_NS 10
`define FESP_RD_NS 90
`define FESP_WR_NS 45
`define FESP_REC_NS 45
// Two extra cycles cover the data synchroniser
`define FESP_RD_CYC ((`FESP_RD_NS + `FESP_CLK_NS - 1) / `FESP_CLK_NS + 2)
`define FESP_WR_CYC ((`FESP_WR_NS + `FESP_CLK_NS - 1) / `FESP_CLK_NS)
`define FESP_REC_CYC ((`FESP_REC_NS + `FESP_CLK_NS - 1) / `FESP_CLK_NS)
`define FESP_PROT_CYC_DEF 1000
`define FESP_HVSET_CYC_DEF 400
`endif

// file: hw/fesp_pkg.sv
// Types shared by the flash sequencer.
// Assumes fesp_regs.svh supplies the numeric constants.
package fesp_pkg;
   typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_POLL, OP_PROT,
      OP_UNPROT} fesp_op_e;
   typedef enum logic [2:0] {S_IDLE, S_RD, S_RD_GAP, S_WR, S_WR_REC,
      S_HV_SET, S_HV_PULSE, S_HV_REL} fesp_state_e;
   typedef logic [7:0] fesp_byte_t;
endpackage

// file: hw/fesp_ctrl.sv
// Host-side sequencer driving a byte-wide NOR flash through its pins.
// Assumes an AXI4-Lite master, external high-voltage switches and pads.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "fesp_regs.svh"
module fesp_ctrl
#(
   parameter int PROT_CYC = `FESP_PROT_CYC_DEF,
   parameter int HVSET_CYC = `FESP_HVSET_CYC_DEF
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Flash pins
   output logic [18:0] fl_addr,
   output fesp_pkg::fesp_byte_t fl_dq_o,
   output logic fl_dq_oe,
   input wire fesp_pkg::fesp_byte_t fl_dq_i,
   output logic fl_chip_select_n,
   output logic fl_write_strobe_n,
   output logic fl_output_enable_n,
   input wire logic fl_ready_busy_n,
   // High-voltage switch enables
   output logic fl_hv_reset,
   output logic fl_hv_a9,
   output logic fl_hv_oe
);
   import fesp_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a == `FESP_CTRL_OFS || a == `FESP_ADDR_OFS ||
         a == `FESP_WDATA_OFS || a == `FESP_STATUS_OFS ||
         a == `FESP_RDATA_OFS || a == `FESP_HV_OFS;
   endfunction

   // Bus side
   logic [7:0] awa_q;
   logic [31:0] wd_q;
   logic [3:0] wstrb_q;
   logic [18:0] addr_q;
   fesp_byte_t wdata_q;
   logic [1:0] hv_ctl_q;
   // Sequencer
   fesp_state_e state_q, state_d;
   fesp_op_e op_q;
   logic chk_q, hv_seq_q, saw_to_q, prev_tog_q, rej_q, fail_q, refused_q;
   logic [1:0] ph_q;
   logic [15:0] cnt_q, cnt_load;
   fesp_byte_t rdata_q, dq_m_q, dq_s_q;
   logic rb_m_q, rb_s_q;

   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs = s_axi_wvalid & s_axi_wready;
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   wire wr_do = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   wire [31:0] wr_merged = merge(32'h0000_0000, wd_q, wstrb_q);
   wire [31:0] addr_merged = merge({13'h0, addr_q}, wd_q, wstrb_q);
   wire wr_ctrl = wr_do & awa_q == `FESP_CTRL_OFS & wstrb_q[0];
   wire go = wr_ctrl & wd_q[`FESP_CTRL_GO];
   wire fesp_op_e go_op = fesp_op_e'(wd_q[`FESP_CTRL_OP_LSB +: 3]);
   wire op_valid = go_op <= OP_UNPROT;
   // A failed operation leaves the reset command as the only write that may start
   wire blocked = fail_q & go_op == OP_WRITE &
      wdata_q != `FESP_CMD_RESET;
   wire start = go & state_q == S_IDLE & op_valid & ~blocked;
   wire refuse = go & ~start;
   wire cnt_done = cnt_q == 16'h0000;
   wire rd_end = state_q == S_RD & cnt_done;
   wire tog_chg = dq_s_q[`FESP_BIT_TOGGLE] ^ prev_tog_q;
   // Toggle still running after timeout_flag was seen means failure
   wire poll_fail = op_q == OP_POLL & ph_q != 2'h0 & tog_chg &
      saw_to_q;
   wire poll_more = op_q == OP_POLL & (ph_q == 2'h0 | (tog_chg & ~saw_to_q));
   wire [31:0] status_w = {27'h0, rb_s_q, refused_q, fail_q, rej_q,
      state_q != S_IDLE};
   wire [31:0] rd_word =
      s_axi_araddr == `FESP_CTRL_OFS ? {27'h0, chk_q, op_q, 1'b0} :
      s_axi_araddr == `FESP_ADDR_OFS ? {13'h0, addr_q} :
      s_axi_araddr == `FESP_WDATA_OFS ? {24'h0, wdata_q} :
      s_axi_araddr == `FESP_STATUS_OFS ? status_w :
      s_axi_araddr == `FESP_RDATA_OFS ? {24'h0, rdata_q} :
      s_axi_araddr == `FESP_HV_OFS ? {30'h0, hv_ctl_q} : 32'h0000_0000;
   wire hv_d = state_d == S_HV_SET | state_d == S_HV_PULSE |
      state_d == S_HV_REL;

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FESP_RESP_OK;
         awa_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end
      else
      begin
         if (aw_hs)
         begin
            awa_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (w_hs)
         begin
            wd_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_do)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awa_q) ? `FESP_RESP_OK : `FESP_RESP_ERR;
         end
         if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `FESP_RESP_OK;
      end
      else if (ar_hs)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= mapped(s_axi_araddr) ? `FESP_RESP_OK : `FESP_RESP_ERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Configuration words; the sequencer latches address and data at start, the HV word drives the reset and A9 switches directly
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         addr_q <= 19'h00000;
         wdata_q <= 8'h00;
         hv_ctl_q <= 2'h0;
      end
      else if (wr_do)
      begin
         if (awa_q == `FESP_ADDR_OFS)
            addr_q <= addr_merged[18:0];
         if (awa_q == `FESP_WDATA_OFS & wstrb_q[0])
            wdata_q <= wr_merged[7:0];
         if (awa_q == `FESP_HV_OFS & wstrb_q[0])
            hv_ctl_q <= wr_merged[1:0];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dq_m_q <= 8'h00;
         dq_s_q <= 8'h00;
         rb_m_q <= 1'b1;
         rb_s_q <= 1'b1;
      end
      else
      begin
         dq_m_q <= fl_dq_i;
         dq_s_q <= dq_m_q;
         rb_m_q <= fl_ready_busy_n;
         rb_s_q <= rb_m_q;
      end
   end

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         S_IDLE:
            if (start)
            begin
               if (go_op == OP_PROT || go_op == OP_UNPROT)
                  state_d = S_HV_SET;
               else if (go_op == OP_WRITE && !wd_q[`FESP_CTRL_CHK])
                  state_d = S_WR;
               else
                  state_d = S_RD;
            end
         S_RD:
            if (cnt_done)
            begin
               if (op_q == OP_WRITE && ph_q == 2'h0)
                  state_d = S_WR;
               else if (poll_more)
                  state_d = S_RD_GAP;
               else
                  state_d = S_IDLE;
            end
         S_RD_GAP: if (cnt_done) state_d = S_RD;
         S_WR: if (cnt_done) state_d = S_WR_REC;
         // The second flag read tells if the extra erase was refused
         S_WR_REC: if (cnt_done) state_d = chk_q ? S_RD : S_IDLE;
         S_HV_SET: if (cnt_done) state_d = S_HV_PULSE;
         S_HV_PULSE: if (cnt_done) state_d = S_HV_REL;
         S_HV_REL: if (cnt_done) state_d = S_IDLE;
         default: state_d = S_IDLE;
      endcase
   end

   always_comb
   begin
      case (state_d)
         S_RD: cnt_load = 16'(`FESP_RD_CYC - 1);
         S_WR: cnt_load = 16'(`FESP_WR_CYC - 1);
         S_RD_GAP, S_WR_REC: cnt_load = 16'(`FESP_REC_CYC - 1);
         S_HV_PULSE: cnt_load = 16'(PROT_CYC - 1);
         S_HV_SET, S_HV_REL: cnt_load = 16'(HVSET_CYC - 1);
         default: cnt_load = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= S_IDLE;
         cnt_q <= 16'h0000;
         op_q <= OP_READ;
         chk_q <= 1'b0;
         ph_q <= 2'h0;
         saw_to_q <= 1'b0;
         prev_tog_q <= 1'b0;
         rdata_q <= 8'h00;
         rej_q <= 1'b0;
         fail_q <= 1'b0;
         refused_q <= 1'b0;
         hv_seq_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= state_d != state_q ? cnt_load : cnt_q - 16'h0001;
         hv_seq_q <= hv_d;
         if (start)
         begin
            op_q <= go_op;
            chk_q <= wd_q[`FESP_CTRL_CHK];
            ph_q <= 2'h0;
            saw_to_q <= 1'b0;
            rej_q <= 1'b0;
            refused_q <= 1'b0;
         end
         else if (refuse)
            refused_q <= 1'b1;
         if (rd_end)
         begin
            rdata_q <= dq_s_q;
            prev_tog_q <= dq_s_q[`FESP_BIT_TOGGLE];
            ph_q <= ph_q == 2'h3 ? ph_q : ph_q + 2'h1;
            if (ph_q != 2'h0)
               saw_to_q <= dq_s_q[`FESP_BIT_TIMEOUT];
            if (op_q == OP_WRITE && ph_q != 2'h0 &&
               dq_s_q[`FESP_BIT_WINDOW])
               rej_q <= 1'b1;
            if (poll_fail)
               fail_q <= 1'b1;
         end
         if (state_q == S_WR && cnt_done && op_q == OP_WRITE &&
            fl_dq_o == `FESP_CMD_RESET)
            fail_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fl_addr <= 19'h00000;
         fl_dq_o <= 8'h00;
         fl_dq_oe <= 1'b0;
         fl_chip_select_n <= 1'b1;
         fl_write_strobe_n <= 1'b1;
         fl_output_enable_n <= 1'b1;
         fl_hv_reset <= 1'b0;
         fl_hv_a9 <= 1'b0;
         fl_hv_oe <= 1'b0;
      end
      else
      begin
         if (start)
         begin
            fl_addr <= addr_q;
            if (go_op == OP_UNPROT)
               fl_addr[`FESP_UNPROT_ABIT] <= 1'b1;
            fl_dq_o <= wdata_q;
         end
         fl_dq_oe <= state_d == S_WR;
         fl_chip_select_n <= state_d == S_IDLE | state_d == S_WR_REC |
            state_d == S_RD_GAP;
         fl_write_strobe_n <= ~(state_d == S_WR | state_d == S_HV_PULSE);
         fl_output_enable_n <= state_d != S_RD;
         fl_hv_reset <= hv_ctl_q[`FESP_HV_RST];
         fl_hv_a9 <= hv_ctl_q[`FESP_HV_A9] | hv_seq_q;
         fl_hv_oe <= hv_seq_q;
      end
   end

   a_write_inhibit: assert property (@(posedge core_clk) disable iff
      (!arst_n) !fl_write_strobe_n |-> fl_output_enable_n &&
      !fl_chip_select_n) else $error("write strobe without inhibit off");
   a_strobe_width: assert property (@(posedge core_clk) disable iff
      (!arst_n) $fell(fl_write_strobe_n) && !fl_hv_oe |->
      !fl_write_strobe_n [*5]) else $error("write strobe too short");
   a_fail_blocks: assert property (@(posedge core_clk) disable iff
      (!arst_n) $fell(fl_write_strobe_n) && fail_q && !fl_hv_oe |->
      fl_dq_o == `FESP_CMD_RESET) else $error("write issued after fail");
   a_hv_pulse: assert property (@(posedge core_clk) disable iff
      (!arst_n) !fl_write_strobe_n && state_q == S_HV_PULSE |->
      fl_hv_a9 && fl_hv_oe) else $error("protect pulse without HV");
   a_unprot_addr: assert property (@(posedge core_clk) disable iff
      (!arst_n) state_q == S_HV_PULSE && op_q == OP_UNPROT |->
      fl_addr[`FESP_UNPROT_ABIT] && !fl_chip_select_n)
      else $error("unprotect pulse set up wrong");
   a_window_flag: assert property (@(posedge core_clk) disable iff
      (!arst_n) $rose(rej_q) |-> $past(dq_s_q[`FESP_BIT_WINDOW]) &&
      $past(state_q) == S_RD) else $error("reject flag without cause");
   a_fail_cause: assert property (@(posedge core_clk) disable iff
      (!arst_n) $rose(fail_q) |-> $past(saw_to_q) && op_q == OP_POLL)
      else $error("fail flag without timeout");
   a_poll_reads: assert property (@(posedge core_clk) disable iff
      (!arst_n) $rose(state_q == S_RD_GAP) |-> fl_output_enable_n [*5]
      ##1 !fl_output_enable_n) else $error("poll reads not separated");
   a_read_answer: assert property (@(posedge core_clk) disable iff
      (!arst_n) ar_hs |=> s_axi_rvalid ##0 !s_axi_arready)
      else $error("read not answered next cycle");
endmodule

// file: bench/fesp_flash_model.sv
// Behavioural byte-wide NOR flash facing the sequencer pins.
// Assumes the bench resolves the data bus and inverts busy onto the ready/busy pin.
`timescale 1ns/100ps
module fesp_flash_model
#(
   parameter logic [18:0] FAIL_ADDR = 19'h7FFF0
)
(
   // Address, data and strobes
   input wire logic [18:0] addr,
   input wire logic [7:0] dq_in,
   input wire logic cs_n,
   input wire logic we_n,
   input wire logic oe_n,
   // High-voltage levels
   input wire logic hv_reset,
   input wire logic hv_a9,
   input wire logic hv_oe,
   // Model outputs
   output logic [7:0] dq_out,
   output logic busy
);
   logic [7:0] mem [int];
   logic [7:0] prot = 8'h00;
   logic [7:0] ers = 8'h00;
   logic [7:0] pd = 8'h00;
   logic [2:0] step = 3'd0;
   logic tog = 0;
   logic tmo = 0;
   logic win = 0;
   logic fail_go = 0;
   logic wr_ok = 0;
   logic erasing = 0;
   logic id_m = 0;
   int reads = 0;
   realtime t_fall = 0;
   initial
      busy = 0;
   initial
      dq_out = 8'h00;
   function automatic logic open_s(input logic [2:0] s);
      return !prot[s] || hv_reset;
   endfunction
   function automatic logic [7:0] rd_arr(input logic [18:0] a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction
   function automatic logic [2:0] nx(input logic [2:0] s, input logic [7:0] d);
      case ({s, d})
         {3'd0, 8'hAA}, {3'd4, 8'hAA}, {3'd1, 8'h55}, {3'd5, 8'h55}:
            return s + 3'd1;
         {3'd2, 8'hA0}: return 3'd3;
         {3'd2, 8'h80}: return 3'd4;
         default: return 3'd0;
      endcase
   endfunction
   task automatic start(input logic er);
      busy = 1;
      win = 0;
      reads = 0;
      erasing = er;
   endtask
   task automatic wr_cycle();
      if (hv_a9 && hv_oe)
      begin
         if (addr[6])
            prot = 8'h00;
         else
            prot[addr[18:16]] = 1'b1;
      end
      else if (dq_in == 8'hF0 && (!busy || tmo))
      begin
         step = 0;
         id_m = 0;
         tmo = 0;
         busy = 0;
      end
      else if (busy)
      begin
         // Only an extra erase inside the open window counts
         if (erasing && !win && dq_in == 8'h30 && open_s(addr[18:16]))
            ers[addr[18:16]] = 1'b1;
      end
      else if (step == 3)
      begin
         step = 0;
         pd = dq_in;
         fail_go = (addr == FAIL_ADDR);
         if (open_s(addr[18:16]) && !fail_go)
            mem[addr] = rd_arr(addr) & dq_in;
         if (open_s(addr[18:16]))
            start(0);
      end
      else if (step == 6)
      begin
         step = 0;
         ers = 8'h00;
         ers[addr[18:16]] = 1'b1;
         fail_go = 0;
         if (dq_in == 8'h30 && open_s(addr[18:16]))
            start(1);
      end
      else
      begin
         id_m = id_m || (step == 2 && dq_in == 8'h90);
         step = nx(step, dq_in);
      end
   endtask
   task automatic rd_cycle();
      if ((hv_a9 || id_m) && addr[1])
         dq_out = {7'h00, prot[addr[18:16]]};
      else if (busy)
      begin
         tog = ~tog;
         reads++;
         tmo = tmo || (fail_go && reads == 2);
         win = win || (erasing && reads == 3);
         dq_out = {erasing ? 1'b0 : ~pd[7], tog, tmo, 1'b0, win,
            3'h0};
         if (!fail_go && reads == (erasing ? 6 : 3))
            busy = 0;
         if (!busy && erasing)
            foreach (mem[k])
               if (ers[k[18:16]])
                  mem[k] = 8'hFF;
      end
      else
         dq_out = rd_arr(addr);
   endtask
   // Select and enable may move on the strobe's own edges; judge them
   // 1ns into the strobe so the closing edge does not race them
   always @(negedge we_n)
   begin
      t_fall = $realtime;
      #1;
      wr_ok = !cs_n && oe_n;
   end
   // Short strobes and cycles with output enable low never write
   always @(posedge we_n)
      if (wr_ok && $realtime - t_fall >= 5.0)
         wr_cycle();
   // Chip select of the same edge must settle before the read starts
   always @(negedge oe_n)
   begin
      #1;
      if (!cs_n)
         rd_cycle();
   end
   always @(posedge oe_n)
      dq_out = ~dq_out;
endmodule

// file: bench/fesp_ctrl_tb_top.sv
// Self-checking bench: sequencer, AXI4-Lite driver and flash model.
// Assumes fesp_ctrl, fesp_flash_model and fesp_regs.svh are compiled.
`timescale 1ns/100ps
`include "fesp_regs.svh"
module fesp_ctrl_tb_top;
   import fesp_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r; logic w;}
      fesp_row_s;
   logic core_clk = 0;
   logic arst_n = 0;
   logic [7:0] awaddr = 0;
   logic [7:0] araddr = 0;
   logic [31:0] wdata = 0;
   logic awvalid = 0;
   logic wvalid = 0;
   logic bready = 0;
   logic arvalid = 0;
   logic rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, v;
   logic [18:0] fl_addr;
   fesp_byte_t dq_o, dq_i, fm_dq;
   logic dq_oe, cs_n, we_n, oe_n, hv_r, hv_a9, hv_oe, fm_busy;
   int n_fail = 0;
   int n_checks = 0;
   fesp_row_s rows [7] = '{'{8'h0C, 32'h10, 0, 0}, '{8'h14, 32'h0, 0, 0},
      '{8'h14, 32'h3, 0, 1}, '{8'h14, 32'h3, 0, 0}, '{8'h14, 32'h0, 0, 1},
      '{8'h18, 32'h0, 2, 0}, '{8'h1C, 32'h5, 2, 1}};
   assign dq_i = dq_oe ? dq_o : fm_dq;
   fesp_ctrl #(.PROT_CYC(4), .HVSET_CYC(2)) fesp_ctrl_inst (
      .core_clk(core_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .fl_addr(fl_addr), .fl_dq_o(dq_o),
      .fl_dq_oe(dq_oe), .fl_dq_i(dq_i), .fl_chip_select_n(cs_n),
      .fl_write_strobe_n(we_n), .fl_output_enable_n(oe_n),
      .fl_ready_busy_n(~fm_busy), .fl_hv_reset(hv_r), .fl_hv_a9(hv_a9),
      .fl_hv_oe(hv_oe));
   fesp_flash_model #(.FAIL_ADDR(19'h50000)) fesp_flash_model_inst (
      .addr(fl_addr), .dq_in(dq_o), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n),
      .hv_reset(hv_r), .hv_a9(hv_a9), .hv_oe(hv_oe), .dq_out(fm_dq),
      .busy(fm_busy));
   initial
      forever #5 core_clk = ~core_clk;
   task automatic print_verdict();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw;
      logic w;
      @(posedge core_clk);
      aw = 1;
      w = 1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (aw || w)
      begin
         @(posedge core_clk);
         if (aw && awready)
            awvalid <= 0;
         if (w && wready)
            wvalid <= 0;
         aw = aw && !awready;
         w = w && !wready;
      end
      do @(posedge core_clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge core_clk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge core_clk); while (rvalid !== 1'b1);
      v = rdata;
      r = rresp;
      rready <= 0;
   endtask
   task automatic fop(input logic [18:0] a, input logic [7:0] d,
      input logic [3:0] c);
      wr(`FESP_ADDR_OFS, {13'h0, a});
      wr(`FESP_WDATA_OFS, {24'h0, d});
      wr(`FESP_CTRL_OFS, {27'h0, c, 1'b1});
      do rd(`FESP_STATUS_OFS); while (v[0] !== 1'b0);
   endtask
   task automatic cmd3(input logic [7:0] c);
      fop(19'h555, 8'hAA, 4'h1);
      fop(19'h2AA, 8'h55, 4'h1);
      fop(19'h555, c, 4'h1);
   endtask
   task automatic prog(input logic [18:0] a, input logic [7:0] d);
      cmd3(8'hA0);
      fop(a, d, 4'h1);
      fop(a, 8'h00, 4'h2);
   endtask
   task automatic peek(input logic [18:0] a, input logic [7:0] e);
      fop(a, 8'h00, 4'h0);
      rd(`FESP_RDATA_OFS);
      chk("flash byte", {24'h0, e}, v);
   endtask
   task automatic stat(input logic [31:0] e);
      rd(`FESP_STATUS_OFS);
      chk("status", e, v);
   endtask
   initial
   begin
      #500us;
      n_fail++;
      $display("BAD watchdog expected done seen hang");
      print_verdict();
   end
   initial
   begin
      repeat (12) @(posedge core_clk);
      arst_n <= 1;
      foreach (rows[i])
      begin
         if (rows[i].w)
            wr(rows[i].a, rows[i].d);
         else
            rd(rows[i].a);
         if (!rows[i].w)
            chk("rdata", rows[i].d, v);
         chk("resp", {30'h0, rows[i].r}, {30'h0, r});
      end
      peek(19'h00123, 8'hFF);
      prog(19'h00123, 8'h5A);
      stat(32'h10);
      prog(19'h00123, 8'h0F);
      stat(32'h10);
      peek(19'h00123, 8'h0A);
      fop(19'h555, 8'hAA, 4'h1);
      fop(19'h555, 8'hA0, 4'h1);
      fop(19'h00124, 8'h33, 4'h1);
      peek(19'h00124, 8'hFF);
      fop(19'h10000, 8'h00, 4'h3);
      wr(`FESP_HV_OFS, 32'h2);
      peek(19'h10002, 8'h01);
      peek(19'h000C2, 8'h00);
      wr(`FESP_HV_OFS, 32'h0);
      prog(19'h10020, 8'h21);
      peek(19'h10020, 8'hFF);
      wr(`FESP_HV_OFS, 32'h1);
      prog(19'h10020, 8'h21);
      peek(19'h10020, 8'h21);
      wr(`FESP_HV_OFS, 32'h0);
      prog(19'h10030, 8'h31);
      peek(19'h10030, 8'hFF);
      cmd3(8'h90);
      peek(19'h10002, 8'h01);
      fop(19'h0, 8'hF0, 4'h1);
      for (int s = 0; s < 8; s++)
         fop({s[2:0], 16'h0000}, 8'h00, 4'h3);
      fop(19'h0, 8'h00, 4'h4);
      cmd3(8'h90);
      peek(19'h10002, 8'h00);
      fop(19'h0, 8'hF0, 4'h1);
      prog(19'h50000, 8'h11);
      stat(32'h04);
      fop(19'h00200, 8'h12, 4'h1);
      stat(32'h0C);
      fop(19'h0, 8'hF0, 4'h1);
      stat(32'h10);
      peek(19'h00123, 8'h0A);
      prog(19'h30010, 8'h3C);
      prog(19'h40010, 8'h4C);
      cmd3(8'h80);
      fop(19'h555, 8'hAA, 4'h1);
      fop(19'h2AA, 8'h55, 4'h1);
      fop(19'h20000, 8'h30, 4'h1);
      fop(19'h30000, 8'h30, 4'h9);
      stat(32'h00);
      fop(19'h40000, 8'h30, 4'h9);
      stat(32'h02);
      fop(19'h20000, 8'h00, 4'h2);
      peek(19'h30010, 8'hFF);
      peek(19'h40010, 8'h4C);
      // Reset in mid-run must drop every high-voltage switch at once
      wr(`FESP_HV_OFS, 32'h3);
      @(posedge core_clk);
      chk("hv pins", 32'h6, {29'h0, hv_r, hv_a9, hv_oe});
      arst_n <= 0;
      repeat (2) @(posedge core_clk);
      chk("hv pins", 32'h0, {29'h0, hv_r, hv_a9, hv_oe});
      arst_n <= 1;
      stat(32'h10);
      rd(`FESP_HV_OFS);
      chk("hv reg", 32'h0, v);
      print_verdict();
   end
endmodule
